// [hdl/ssp_top.sv]
// serial eeprom status register, write protection and pin control
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_top #(
  parameter logic [15:0] WRITE_CYCLES = `SSP_WRITE_CYCLES
) (
  input  wire logic             clock,          // 25 MHz system clock
  input  wire logic             rst,            // sync reset, power-up
  input  wire logic             cs_n,           // select, active low
  input  wire logic             sck,            // serial clock from master
  input  wire logic             si,             // serial data in
  input  wire logic             pause_n,        // pause, active low
  input  wire logic             protect_n,      // write protect pin, active low
  input  wire ssp_pkg::ssp_nv_t nv_image,       // retained nonvolatile bits
  output logic                  so,             // serial data out
  output logic                  so_oe,          // serial out enable
  output logic                  array_wr_start, // array write cycle start pulse
  output logic [13:0]           array_wr_addr,  // array write start address
  output logic                  standby,        // deselected and idle
  output ssp_pkg::ssp_nv_t      nv_image_out    // bits to retain
);
  import ssp_pkg::*;

  ssp_nv_if nvi ();

  logic      cs_lvl;
  logic      sck_lvl;
  logic      si_lvl;
  logic      pause_lvl;
  logic      protect_lvl;
  logic      cs_prev;
  logic      sck_prev;
  logic      pause_prev;
  logic      active;
  logic      paused;
  logic      write_latch_flag;
  logic      wp_low_seen;
  logic      read_mode;
  logic [2:0] bit_cnt;
  logic [2:0] byte_cnt;
  ssp_byte_t shift_in;
  ssp_byte_t opcode;
  ssp_byte_t byte1;
  ssp_byte_t byte2;
  ssp_byte_t snap;
  ssp_byte_t status_now;
  ssp_byte_t next_shift;
  logic      cs_fall;
  logic      cs_rise;
  logic      sck_rise;
  logic      sck_fall;
  logic      pause_rise;
  logic      run;
  logic      frame_whole;
  logic      set_latch;
  logic      clr_latch;
  logic      hw_protect;
  logic      addr_guarded;
  logic      go_status;
  logic      go_array;
  logic [13:0] wr_addr;

  ssp_pin_sync #(.INIT(1'b1)) u_cs (.clock(clock), .rst(rst), .pin(cs_n), .level(cs_lvl));
  ssp_pin_sync #(.INIT(1'b0)) u_sck (.clock(clock), .rst(rst), .pin(sck), .level(sck_lvl));
  ssp_pin_sync #(.INIT(1'b0)) u_si (.clock(clock), .rst(rst), .pin(si), .level(si_lvl));
  ssp_pin_sync #(.INIT(1'b1)) u_pause (.clock(clock), .rst(rst), .pin(pause_n), .level(pause_lvl));
  ssp_pin_sync #(.INIT(1'b1)) u_prot (.clock(clock), .rst(rst), .pin(protect_n), .level(protect_lvl));

  ssp_nv_store #(.CYCLES(WRITE_CYCLES)) u_nv (
    .clock    (clock),
    .rst      (rst),
    .nv_image (nv_image),
    .nvi      (nvi)
  );

  always_ff @(posedge clock) begin
    if (rst) begin
      cs_prev    <= 1'b1;
      sck_prev   <= 1'b0;
      pause_prev <= 1'b1;
    end else begin
      cs_prev    <= cs_lvl;
      sck_prev   <= sck_lvl;
      pause_prev <= pause_lvl;
    end
  end

  assign cs_fall    = cs_prev && !cs_lvl;
  assign cs_rise    = !cs_prev && cs_lvl;
  assign sck_rise   = !sck_prev && sck_lvl;
  assign sck_fall   = sck_prev && !sck_lvl;
  assign pause_rise = !pause_prev && pause_lvl;
  assign run        = active && !paused;

  // a select held low through power-up still arms the link: the filtered level resets high, so a falling edge follows
  always_ff @(posedge clock) begin
    if (rst) begin
      active <= 1'b0;
    end else if (cs_rise) begin
      active <= 1'b0;
    end else if (cs_fall) begin
      active <= 1'b1;
    end
  end

  // pause only takes hold with the clock low; a high clock defers it to the fall
  always_ff @(posedge clock) begin
    if (rst || !active) begin
      paused <= 1'b0;
    end else if (!paused && !pause_lvl && !sck_lvl) begin
      paused <= 1'b1;
    end else if (paused && pause_rise && !sck_lvl) begin
      paused <= 1'b0;
    end
  end

  assign next_shift = {shift_in[6:0], si_lvl};

  always_ff @(posedge clock) begin
    if (rst || cs_fall) begin
      shift_in <= 8'h00;
      bit_cnt  <= 3'h0;
      byte_cnt <= 3'h0;
    end else if (run && sck_rise) begin
      shift_in <= next_shift;
      bit_cnt  <= bit_cnt + 3'h1;
      if (bit_cnt == 3'h7 && byte_cnt != 3'h7) byte_cnt <= byte_cnt + 3'h1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || cs_fall) begin
      opcode <= 8'h00;
      byte1  <= 8'h00;
      byte2  <= 8'h00;
    end else if (run && sck_rise && bit_cnt == 3'h7) begin
      case (byte_cnt)
        3'h0: opcode <= next_shift;
        3'h1: byte1 <= next_shift;
        3'h2: byte2 <= next_shift;
        default: opcode <= opcode;
      endcase
    end
  end

  // with the pen bit set, any low protect level inside the frame refuses the status write
  always_ff @(posedge clock) begin
    if (rst) begin
      wp_low_seen <= 1'b0;
    end else if (cs_fall) begin
      wp_low_seen <= !protect_lvl;
    end else if (active && !protect_lvl) begin
      wp_low_seen <= 1'b1;
    end
  end

  assign status_now = {nvi.bits[2], 3'h0, nvi.bits[1], nvi.bits[0], write_latch_flag, nvi.busy};
  assign hw_protect = nvi.bits[2] && wp_low_seen;
  assign wr_addr    = {byte1[5:0], byte2};

  always_comb begin
    case (nvi.bits[1:0])
      2'b01:   addr_guarded = wr_addr >= `SSP_GUARD_QUARTER;
      2'b10:   addr_guarded = wr_addr >= `SSP_GUARD_HALF;
      2'b11:   addr_guarded = 1'b1;
      default: addr_guarded = 1'b0;
    endcase
  end

  assign frame_whole = active && cs_rise && bit_cnt == 3'h0;
  assign set_latch   = frame_whole && opcode == `SSP_OP_LATCH_SET && byte_cnt == 3'h1;
  assign clr_latch   = frame_whole && opcode == `SSP_OP_LATCH_CLR && byte_cnt == 3'h1;
  assign go_status   = frame_whole && opcode == `SSP_OP_STATUS_WR && byte_cnt == 3'h2
                       && write_latch_flag && !nvi.busy && !hw_protect;
  assign go_array    = frame_whole && opcode == `SSP_OP_ARRAY_WR && byte_cnt >= 3'h4
                       && write_latch_flag && !nvi.busy && !addr_guarded;

  always_comb begin
    nvi.start        = go_status || go_array;
    nvi.start_status = go_status;
    nvi.new_bits     = {byte1[7], byte1[3], byte1[2]};
  end

  // set wins over the end-of-cycle clear
  always_ff @(posedge clock) begin
    if (rst) begin
      write_latch_flag <= 1'b0;
    end else if (set_latch) begin
      write_latch_flag <= 1'b1;
    end else if (clr_latch || nvi.done) begin
      write_latch_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (rst || cs_fall) begin
      read_mode <= 1'b0;
    end else if (run && sck_rise && bit_cnt == 3'h7 && byte_cnt == 3'h0) begin
      read_mode <= next_shift == `SSP_OP_STATUS_RD;
    end
  end

  // status is resampled at each byte start so polling sees busy drop
  always_ff @(posedge clock) begin
    if (rst) begin
      snap <= 8'h00;
      so   <= 1'b0;
    end else if (run && read_mode && sck_fall) begin
      if (bit_cnt == 3'h0) begin
        snap <= status_now;
        so   <= status_now[7];
      end else begin
        so <= snap[3'h7 - bit_cnt];
      end
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      so_oe <= 1'b0;
    end else begin
      // filtered pause level drops the enable on the clock the state freezes, or sooner while sck is high
      so_oe <= active && !cs_rise && read_mode && pause_lvl && !paused;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      array_wr_start <= 1'b0;
      array_wr_addr  <= 14'h0000;
    end else begin
      array_wr_start <= go_array;
      if (go_array) array_wr_addr <= wr_addr;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      standby      <= 1'b1;
      nv_image_out <= `SSP_NV_RESET;
    end else begin
      standby      <= !active && !nvi.busy;
      nv_image_out <= nvi.bits;
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  a_unused_bits_zero: assert property (snap[6:4] == 3'h0)
    else $error("unused status bits not zero");
  a_busy_from_start: assert property ($rose(nvi.busy) |-> $past(nvi.start))
    else $error("busy rose without a start");
  a_latch_after_done: assert property (nvi.done && !set_latch |=> !write_latch_flag)
    else $error("latch not cleared after write cycle");
  a_guard_blocks_array: assert property (array_wr_start |->
    $past(write_latch_flag) && !$past(addr_guarded) && !$past(nvi.busy))
    else $error("array write started in guarded block");
  a_hw_protect_refuse: assert property (nvi.start && nvi.start_status |-> !(nvi.bits[2] && wp_low_seen))
    else $error("status write passed hardware protection");
  a_latch_needed: assert property (nvi.start |-> write_latch_flag)
    else $error("write started with latch clear");
  a_no_start_busy: assert property (nvi.busy |-> !array_wr_start || !$past(nvi.busy))
    else $error("array write started during cycle");
  a_off_when_idle: assert property (!active |=> !so_oe)
    else $error("output driven while deselected");
  a_pause_tristate: assert property (!pause_lvl |=> !so_oe)
    else $error("output driven while paused");
  a_bits_hold_busy: assert property (nvi.busy && !$rose(nvi.busy) |-> $stable(nvi.bits))
    else $error("nonvolatile bits changed mid cycle");
  a_cycle_runs_on: assert property ($rose(nvi.busy) |-> nvi.busy [*8])
    else $error("write cycle ended early");
  a_latch_set_acts: assert property (set_latch |=> write_latch_flag && status_now[1])
    else $error("latch set command ignored");
  a_standby_waits: assert property (nvi.busy |=> !standby)
    else $error("standby entered during write cycle");
  a_resume_low_clk: assert property ($fell(paused) && $past(active) |->
    $past(pause_rise) && !$past(sck_lvl))
    else $error("pause released without a low clock");

  c_status_read: cover property (read_mode && sck_fall && bit_cnt == 3'h0);
  c_status_write: cover property (go_status);
  c_pause_seen: cover property ($rose(paused));
  c_refused: cover property (frame_whole && opcode == `SSP_OP_STATUS_WR && hw_protect && write_latch_flag);
  c_array_write: cover property (go_array);
endmodule

// [shared/ssp_defines.svh]
// constants of the status and write-protect block
`ifndef SSP_DEFINES_SVH
`define SSP_DEFINES_SVH
`define SSP_BIT_PEN        3'h7
`define SSP_BIT_GUARD_HI   3'h3
`define SSP_BIT_GUARD_LO   3'h2
`define SSP_BIT_LATCH      3'h1
`define SSP_BIT_BUSY       3'h0
`define SSP_OP_STATUS_WR   8'h01
`define SSP_OP_ARRAY_WR    8'h02
`define SSP_OP_ARRAY_RD    8'h03
`define SSP_OP_LATCH_CLR   8'h04
`define SSP_OP_STATUS_RD   8'h05
`define SSP_OP_LATCH_SET   8'h06
`define SSP_GUARD_QUARTER  14'h3000
`define SSP_GUARD_HALF     14'h2000
`define SSP_WRITE_CYCLES   16'h03e8
`define SSP_NV_RESET       3'h0
`endif

// [shared/ssp_pkg.sv]
// types of the status and write-protect block
package ssp_pkg;
  typedef logic [2:0] ssp_nv_t;   // {pen, guard_hi, guard_lo}
  typedef logic [7:0] ssp_byte_t;
endpackage

// [shared/ssp_nv_if.sv]
// link between frame logic and nonvolatile store
`timescale 1ns/10ps
interface ssp_nv_if;
  import ssp_pkg::*;
  logic    start;
  logic    start_status;
  ssp_nv_t new_bits;
  ssp_nv_t bits;
  logic    busy;
  logic    done;
  modport ctrl  (output start, output start_status, output new_bits, input bits, input busy, input done);
  modport store (input start, input start_status, input new_bits, output bits, output busy, output done);
endinterface

// [hdl/ssp_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/10ps
module ssp_pin_sync #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clock,  // system clock
  input  wire logic rst,    // sync reset
  input  wire logic pin,    // asynchronous pin
  output logic      level   // filtered level
);
  logic s1;
  logic s2;
  logic s3;

  always_ff @(posedge clock) begin
    if (rst) begin
      s1 <= INIT;
      s2 <= INIT;
      s3 <= INIT;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      level <= INIT;
    end else if (s2 == s3) begin
      level <= s3;
    end
  end
endmodule

// [hdl/ssp_nv_store.sv]
// nonvolatile status bits and self-timed write cycle
`timescale 1ns/10ps
`include "ssp_defines.svh"
module ssp_nv_store #(
  parameter logic [15:0] CYCLES = `SSP_WRITE_CYCLES
) (
  input  wire logic            clock,     // system clock
  input  wire logic            rst,       // sync reset
  input  wire ssp_pkg::ssp_nv_t nv_image, // retained bits loaded at reset
  ssp_nv_if.store              nvi        // frame logic side
);
  import ssp_pkg::*;
  logic [15:0] timer;
  logic        pending_status;
  ssp_nv_t     pending_bits;

  // bits are only committed when the cycle ends, so a late protect pin cannot spoil them
  always_ff @(posedge clock) begin
    if (rst) begin
      nvi.busy <= 1'b0;
      nvi.done <= 1'b0;
      timer    <= 16'h0000;
    end else if (nvi.start && !nvi.busy) begin
      nvi.busy <= 1'b1;
      nvi.done <= 1'b0;
      timer    <= CYCLES;
    end else if (nvi.busy && timer == 16'h0001) begin
      nvi.busy <= 1'b0;
      nvi.done <= 1'b1;
      timer    <= 16'h0000;
    end else begin
      nvi.done <= 1'b0;
      if (nvi.busy) timer <= timer - 16'h0001;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      pending_status <= 1'b0;
      pending_bits   <= `SSP_NV_RESET;
    end else if (nvi.start && !nvi.busy) begin
      pending_status <= nvi.start_status;
      pending_bits   <= nvi.new_bits;
    end
  end

  // reset stands for power-up: bits come back from the retained image
  always_ff @(posedge clock) begin
    if (rst) begin
      nvi.bits <= nv_image;
    end else if (nvi.busy && timer == 16'h0001 && pending_status) begin
      nvi.bits <= pending_bits;
    end
  end
endmodule

// [verification/ssp_master_model.sv]
// serial bus master model driving select, clock, data and pause pins
`timescale 1ns/10ps
module ssp_master_model (
  input  wire logic clock,     // system clock
  output logic      cs_n,      // select, active low
  output logic      sck,       // serial clock, still outside frames
  output logic      si,        // serial data to device
  output logic      pause_n,   // pause, active low
  input  wire logic so,        // serial data from device
  input  wire logic so_oe,     // device drives so
  output logic      oe_paused  // so_oe seen while paused
);
  initial begin
    cs_n = 1'b1;
    sck = 1'b0;
    si = 1'b0;
    pause_n = 1'b1;
    oe_paused = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(negedge clock);
  endtask

  // one byte; a pause is inserted before bit pb when pb < 8
  task automatic xfer(input logic [7:0] tx, input int pb, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      if (i == pb) begin
        pause_n = 1'b0;
        wait_clk(8);
        oe_paused = so_oe;
        si = ~si;
        sck = 1'b1;
        wait_clk(4);
        sck = 1'b0;
        wait_clk(4);
        pause_n = 1'b1;
        wait_clk(8);
      end
      si = tx[i];
      wait_clk(4);
      sck = 1'b1;
      wait_clk(4);
      // sampled late: device output trails the clock fall by about five clocks
      rx[i] = so_oe ? so : ~so; // a released line reads as the inverse
      sck = 1'b0;
    end
  endtask

  // frame of n bytes from tx, left aligned; rx keeps the last two bytes seen
  task automatic frame(input logic [31:0] tx, input int n, input int pb, output logic [15:0] rx);
    logic [7:0] b;
    rx = '0;
    cs_n = 1'b0;
    wait_clk(4);
    for (int k = 0; k < n; k++) begin
      xfer(tx[31-8*k -: 8], (k == 1) ? pb : 8, b);
      rx = {rx[7:0], b};
    end
    wait_clk(4);
    cs_n = 1'b1;
    si = ~si;
    wait_clk(8);
  endtask
endmodule

// [verification/tb_top.sv]
// self-checking bench for the status and write-protect block
`timescale 1ns/10ps
module tb_top;
  import ssp_pkg::*;
  // long enough that a read, a latch set and an array write fit inside one cycle
  localparam logic [15:0] WCYC = 16'h0320;
  logic        clock;
  logic        rst;
  logic        cs_n;
  logic        sck;
  logic        si;
  logic        pause_n;
  logic        protect_n;
  logic        so;
  logic        so_oe;
  logic        array_wr_start;
  logic        standby;
  logic        oe_paused;
  logic [13:0] array_wr_addr;
  logic [13:0] last_addr = 14'h0000;
  logic [15:0] rx;
  ssp_nv_t     nv_image;
  ssp_nv_t     nv_image_out;
  int          failures;
  int          checks_done;
  int          starts = 0;
  int          oe_cycles = 0;

  ssp_top #(.WRITE_CYCLES(WCYC)) DUT (
    .clock(clock), .rst(rst), .cs_n(cs_n), .sck(sck), .si(si),
    .pause_n(pause_n), .protect_n(protect_n), .nv_image(nv_image),
    .so(so), .so_oe(so_oe), .array_wr_start(array_wr_start),
    .array_wr_addr(array_wr_addr), .standby(standby), .nv_image_out(nv_image_out)
  );

  ssp_master_model master (
    .clock(clock), .cs_n(cs_n), .sck(sck), .si(si), .pause_n(pause_n),
    .so(so), .so_oe(so_oe), .oe_paused(oe_paused)
  );

  always #20 clock = ~clock;

  // sampled mid-cycle so a one-clock pulse is seen exactly once
  always @(negedge clock) begin
    if (array_wr_start === 1'b1) begin
      starts <= starts + 1;
      last_addr <= array_wr_addr;
    end
    if (so_oe === 1'b1) oe_cycles <= oe_cycles + 1;
  end

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      failures++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wrap_up;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    while (standby !== 1'b1 && n < 3000) begin
      @(negedge clock);
      n++;
    end
    if (standby !== 1'b1) begin
      failures++;
      $display("Error standby expected 1 seen %b", standby);
      wrap_up();
    end
  endtask

  task automatic rd(input logic [7:0] exp, input int pb);
    int oe0;
    oe0 = oe_cycles;
    master.frame({8'h05, 24'h0}, 3, pb, rx);
    check("status bytes", {exp, exp}, rx);
    check("so_oe reading", 16'h1, {15'h0, oe_cycles > oe0});
    check("so_oe deselected", 16'h0, {15'h0, so_oe});
  endtask

  task automatic cmd(input logic [7:0] op);
    master.frame({op, 24'h0}, 1, 8, rx);
  endtask

  task automatic wr_status(input logic [7:0] v);
    master.frame({8'h01, v, 16'h0}, 2, 8, rx);
  endtask

  task automatic arr_wr(input logic [13:0] a);
    master.frame({8'h02, 2'b00, a, 8'h5a}, 4, 8, rx);
  endtask

  task automatic s_power_on;
    check("so_oe", 16'h0, {15'h0, so_oe});
    check("standby", 16'h1, {15'h0, standby});
    check("retained bits", 16'h1, {13'h0, nv_image_out});
    rd(8'h04, 8);
  endtask

  task automatic s_no_latch;
    wr_status(8'h8c);
    arr_wr(14'h0010);
    wait_idle();
    rd(8'h04, 8);
    check("starts", 16'h0, starts[15:0]);
  endtask

  task automatic s_latch;
    cmd(8'h06);
    rd(8'h06, 8);
    cmd(8'h04);
    rd(8'h04, 8);
  endtask

  task automatic s_status_write;
    cmd(8'h06);
    wr_status(8'hf4);
    check("standby busy", 16'h0, {15'h0, standby});
    rd(8'h07, 8);
    cmd(8'h06);
    arr_wr(14'h0000);
    check("starts busy", 16'h0, starts[15:0]);
    wait_idle();
    rd(8'h84, 8);
    check("retained bits", 16'h5, {13'h0, nv_image_out});
  endtask

  // power cycle with the retained bits fed back; the latch must come up clear
  task automatic s_power_cycle;
    cmd(8'h06);
    nv_image = nv_image_out;
    rst = 1'b1;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    check("standby", 16'h1, {15'h0, standby});
    check("so_oe", 16'h0, {15'h0, so_oe});
    check("retained bits", 16'h5, {13'h0, nv_image_out});
    rd(8'h84, 8);
  endtask

  task automatic s_protect;
    protect_n = 1'b0;
    cmd(8'h06);
    arr_wr(14'h2fff);
    check("starts", 16'h1, starts[15:0]);
    check("address", 16'h2fff, {2'b00, last_addr});
    wait_idle();
    rd(8'h84, 8);
    cmd(8'h06);
    arr_wr(14'h3000);
    wr_status(8'h00);
    wait_idle();
    rd(8'h86, 8);
    check("starts", 16'h1, starts[15:0]);
  endtask

  task automatic s_release;
    protect_n = 1'b1;
    wr_status(8'h08);
    protect_n = 1'b0;
    wait_idle();
    rd(8'h08, 8);
    cmd(8'h06);
    wr_status(8'h00);
    wait_idle();
    cmd(8'h06);
    // a lone one bit shows any shift lost or gained across the pause
    rd(8'h02, 4);
    check("so_oe paused", 16'h0, {15'h0, oe_paused});
  endtask

  initial begin
    clock = 1'b0;
    rst = 1'b1;
    protect_n = 1'b1;
    nv_image = 3'b001;
    failures = 0;
    checks_done = 0;
    repeat (6) @(negedge clock);
    rst = 1'b0;
    repeat (6) @(negedge clock);
    s_power_on();
    s_no_latch();
    s_latch();
    s_status_write();
    s_power_cycle();
    s_protect();
    s_release();
    wrap_up();
  end
endmodule
